//--- hw/vpwa_top.sv
// Active symbol classifier and transmit arbitration for a VPW serial link.
// Assumes rxp/txp are the digital receive and transmit lines of a transceiver,
// synchronous to mclk; rxp high means active bus, txp high drives active.
`timescale 1ns/1ps
module vpwa_top (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic rxp,
  output logic txp,
  input wire logic [vpwa_pkg::BYTE_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic tx_go,
  input wire logic transmit_abort_bit,
  output vpwa_pkg::vpwa_sym_t rx_sym,
  output logic rx_sym_valid,
  output logic bus_idle,
  output logic tx_busy,
  output logic tx_done,
  output logic tx_lost
);
  import vpwa_pkg::*;

  logic tick;
  logic rxp_q;
  logic [8:0] act_us_reg;
  logic [8:0] pas_us_reg;
  logic brk_flag_reg;
  logic brk_wait_reg;
  vpwa_sym_t rx_sym_reg;
  logic rx_sym_valid_reg;
  logic bus_idle_reg;
  vpwa_state_t state_reg, state_next;
  logic txp_reg, txp_next;
  logic [8:0] tmr_reg, tmr_next;
  logic [2:0] bit_idx_reg, bit_idx_next;
  logic [3:0] byte_idx_reg, byte_idx_next;
  logic [3:0] load_cnt_reg;
  logic tail_cnt_reg, tail_cnt_next;
  logic prev7_reg, prev7_next;
  logic seen_pas_reg;
  logic tx_busy_reg, tx_done_reg, tx_lost_reg;
  logic done_next, lost_next;
  logic [BYTE_W-1:0] tx_mem [MSG_MAX];
  logic [BYTE_W-1:0] f_data;
  logic f_valid;

  // ----------------------------------------------------------------
  // Tick divider and transmit FIFO
  // ----------------------------------------------------------------
  vpwa_tick u_tick (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick(tick)
  );

  wire f_ready = (state_reg == TX_IDLE) && (load_cnt_reg != MSG_MAX_CNT);

  vpwa_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_data(in_data),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );

  // ----------------------------------------------------------------
  // Receive phase timing
  // ----------------------------------------------------------------
  wire rx_rise = rxp && !rxp_q;
  wire rx_fall = !rxp && rxp_q;
  wire eof_seen = !rxp && (pas_us_reg >= EOF_US);
  wire idle_w = !rxp && (pas_us_reg >= IFS_US);
  wire brk_hit = rxp && (act_us_reg >= RX_D_US) &&
                 !brk_flag_reg;
  wire rx_sync = rx_rise && (pas_us_reg >= EOF_US);

  // Classification by active length at the falling edge
  wire vpwa_sym_t sym_w = (act_us_reg < RX_A_US) ? SYM_INVALID :
                          (act_us_reg < RX_B_US) ? SYM_ONE :
                          (act_us_reg < RX_C_US) ? SYM_ZERO :
                          SYM_SOF;
  wire sym_fire = (rx_fall && !brk_flag_reg) || brk_hit;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxp_q <= 1'b0;
      act_us_reg <= '0;
      pas_us_reg <= US_MAX;
    end else begin
      rxp_q <= rxp;
      if (rx_rise) begin
        act_us_reg <= '0;
      end else if (rxp && tick && act_us_reg != US_MAX) begin
        act_us_reg <= act_us_reg + 9'h001;
      end
      if (rx_fall) begin
        pas_us_reg <= '0;
      end else if (!rxp && tick && pas_us_reg != US_MAX) begin
        pas_us_reg <= pas_us_reg + 9'h001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      brk_flag_reg <= 1'b0;
      brk_wait_reg <= 1'b0;
      rx_sym_reg <= SYM_INVALID;
      rx_sym_valid_reg <= 1'b0;
      bus_idle_reg <= 1'b1;
    end else begin
      brk_flag_reg <= brk_hit || (brk_flag_reg && !rx_fall);
      brk_wait_reg <= brk_hit || (brk_wait_reg && !idle_w);
      rx_sym_valid_reg <= sym_fire;
      if (sym_fire) begin
        rx_sym_reg <= brk_hit ? SYM_BREAK : sym_w;
      end
      bus_idle_reg <= idle_w && !brk_wait_reg;
    end
  end

  // ----------------------------------------------------------------
  // Transmit bit timing and arbitration
  // ----------------------------------------------------------------
  wire in_tail = (state_reg == TX_TAIL);
  wire cur_bit = in_tail || tx_mem[byte_idx_reg][3'h7 - bit_idx_reg];
  // Zero is dominant: shorter passive, longer active
  wire [8:0] bit_dur = txp_reg ? (cur_bit ? ACT_ONE_US : ACT_ZERO_US) :
                                 (cur_bit ? PAS_ONE_US : PAS_ZERO_US);
  wire [8:0] dur_w = (state_reg == TX_SOF) ? SOF_US : bit_dur;
  wire phase_end = tick && (tmr_reg == dur_w - 9'h001);
  wire last_byte = (byte_idx_reg == load_cnt_reg - 4'h1);
  wire arb_st = (state_reg == TX_BIT) || in_tail ||
                ((state_reg == TX_EOFW) && !seen_pas_reg);
  // Passive while the bus is active: a dominant bit beat ours
  wire conflict = arb_st && !txp_reg && rxp &&
                  (tmr_reg >= SETTLE_US);
  wire eighth = !seen_pas_reg && prev7_reg;
  wire start_ok = !brk_wait_reg && (idle_w || rx_sync);
  wire retry_ok = !brk_wait_reg && (eof_seen || rx_sync);

  always_comb begin
    state_next = state_reg;
    txp_next = txp_reg;
    tmr_next = (tick && tmr_reg != US_MAX) ? tmr_reg + 9'h001 : tmr_reg;
    bit_idx_next = bit_idx_reg;
    byte_idx_next = byte_idx_reg;
    tail_cnt_next = tail_cnt_reg;
    prev7_next = prev7_reg;
    done_next = 1'b0;
    lost_next = 1'b0;
    case (state_reg)
      TX_IDLE: begin
        if (tx_go && load_cnt_reg != 4'h0) begin
          state_next = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (start_ok) begin
          state_next = TX_SOF;
          txp_next = 1'b1;
        end
      end
      TX_SOF: begin
        if (phase_end) begin
          state_next = TX_BIT;
          txp_next = 1'b0;
          bit_idx_next = 3'h0;
          byte_idx_next = 4'h0;
          prev7_next = 1'b0;
        end
      end
      TX_BIT: begin
        if (conflict) begin
          lost_next = 1'b1;
          state_next = eighth ? TX_TAIL_SYNC : TX_LOSTW;
          txp_next = 1'b0;
        end else if (phase_end) begin
          txp_next = !txp_reg;
          bit_idx_next = bit_idx_reg + 3'h1;
          prev7_next = (bit_idx_reg == 3'h7);
          if (bit_idx_reg == 3'h7) begin
            if (last_byte) begin
              state_next = TX_EOFW;
            end else begin
              byte_idx_next = byte_idx_reg + 4'h1;
            end
          end
        end
      end
      TX_EOFW: begin
        if (conflict && eighth) begin
          lost_next = 1'b1;
          state_next = TX_TAIL_SYNC;
        end else if (eof_seen) begin
          done_next = 1'b1;
          state_next = TX_IDLE;
        end
      end
      TX_TAIL_SYNC: begin
        if (rx_fall) begin
          state_next = TX_TAIL;
          tail_cnt_next = 1'b0;
          tmr_next = '0;
        end
      end
      TX_TAIL: begin
        if (conflict) begin
          state_next = TX_LOSTW;
          txp_next = 1'b0;
        end else if (phase_end) begin
          if (tail_cnt_reg) begin
            state_next = TX_LOSTW;
            txp_next = 1'b0;
          end else begin
            tail_cnt_next = 1'b1;
            txp_next = 1'b1;
          end
        end
      end
      TX_LOSTW: begin
        if (retry_ok) begin
          state_next = TX_SOF;
          txp_next = 1'b1;
        end
      end
      default: begin
        state_next = TX_IDLE;
        txp_next = 1'b0;
      end
    endcase
    if (transmit_abort_bit) begin
      state_next = TX_IDLE;
      txp_next = 1'b0;
      byte_idx_next = 4'h0;
      bit_idx_next = 3'h0;
    end
    if (txp_next != txp_reg) begin
      tmr_next = '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= TX_IDLE;
      txp_reg <= 1'b0;
      tmr_reg <= '0;
      bit_idx_reg <= '0;
      byte_idx_reg <= '0;
      tail_cnt_reg <= 1'b0;
      prev7_reg <= 1'b0;
      seen_pas_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      txp_reg <= txp_next;
      tmr_reg <= tmr_next;
      bit_idx_reg <= bit_idx_next;
      byte_idx_reg <= byte_idx_next;
      tail_cnt_reg <= tail_cnt_next;
      prev7_reg <= prev7_next;
      seen_pas_reg <= (txp_reg && !txp_next) ? 1'b0 : (seen_pas_reg || !rxp);
    end
  end

  // ----------------------------------------------------------------
  // Message buffer and status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      load_cnt_reg <= '0;
      tx_busy_reg <= 1'b0;
      tx_done_reg <= 1'b0;
      tx_lost_reg <= 1'b0;
    end else begin
      if (transmit_abort_bit || done_next) begin
        load_cnt_reg <= '0;
      end else if (f_valid && f_ready) begin
        load_cnt_reg <= load_cnt_reg + 4'h1;
      end
      tx_busy_reg <= (state_next != TX_IDLE);
      tx_done_reg <= done_next && !transmit_abort_bit;
      tx_lost_reg <= lost_next && !transmit_abort_bit;
    end
  end

  always_ff @(posedge mclk) begin
    if (f_valid && f_ready) begin
      tx_mem[load_cnt_reg] <= f_data;
    end
  end

  assign txp = txp_reg;
  assign rx_sym = rx_sym_reg;
  assign rx_sym_valid = rx_sym_valid_reg;
  assign bus_idle = bus_idle_reg;
  assign tx_busy = tx_busy_reg;
  assign tx_done = tx_done_reg;
  assign tx_lost = tx_lost_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_fall_in(logic [8:0] lo, logic [8:0] hi);
    rx_fall && !brk_flag_reg && act_us_reg >= lo && act_us_reg < hi;
  endsequence

  sequence s_sym(vpwa_sym_t s);
    rx_sym_valid_reg && rx_sym_reg == s;
  endsequence

  a_rx_invalid_bit: assert property (
    s_fall_in(9'h000, RX_A_US) |=> s_sym(SYM_INVALID))
    else $error("short active phase not marked invalid");
  a_rx_one_bit: assert property (
    s_fall_in(RX_A_US, RX_B_US) |=> s_sym(SYM_ONE))
    else $error("active one not decoded");
  a_rx_zero_bit: assert property (
    s_fall_in(RX_B_US, RX_C_US) |=> s_sym(SYM_ZERO))
    else $error("active zero not decoded");
  a_rx_sof_sym: assert property (
    s_fall_in(RX_C_US, RX_D_US) |=> s_sym(SYM_SOF))
    else $error("start of frame not decoded");
  a_rx_break_sym: assert property (
    rxp && act_us_reg == RX_D_US && !brk_flag_reg |=> s_sym(SYM_BREAK))
    else $error("break not recognised");
  a_break_gap_wait: assert property (
    brk_wait_reg && !idle_w && state_reg != TX_SOF |=> state_reg != TX_SOF)
    else $error("send started before gap after break");
  a_busy_bus_wait: assert property (
    state_reg == TX_WAIT && !idle_w && !rx_sync |=> state_reg != TX_SOF)
    else $error("send started on busy bus");
  a_sof_no_arb: assert property (
    state_reg == TX_SOF ##1 state_reg == TX_SOF |-> !tx_lost_reg)
    else $error("arbitration during start of frame");
  a_lose_stop_now: assert property (
    state_reg == TX_BIT && conflict && !eighth && !transmit_abort_bit
    |=> state_reg == TX_LOSTW && !txp_reg ##1 tx_lost_reg == 1'b0)
    else $error("loss did not stop transmission");
  a_tail_after_8th: assert property (
    state_reg == TX_BIT && conflict && eighth && !transmit_abort_bit
    |=> state_reg == TX_TAIL_SYNC && !txp_reg)
    else $error("eighth bit loss did not enter tail");
  a_tail_second_drop: assert property (
    in_tail && !tail_cnt_reg && conflict && !transmit_abort_bit
    |=> (state_reg == TX_LOSTW && !txp_reg) [*2])
    else $error("second tail bit sent after loss");
  a_retry_on_eof: assert property (
    state_reg == TX_LOSTW && retry_ok && !transmit_abort_bit
    |=> state_reg == TX_SOF && txp_reg)
    else $error("no retry at end of frame");
  a_abort_halts: assert property (
    transmit_abort_bit |=> state_reg == TX_IDLE && !txp_reg &&
    byte_idx_reg == 4'h0 && load_cnt_reg == 4'h0)
    else $error("abort did not halt transmission");

endmodule : vpwa_top

//--- hw/vpwa_pkg.sv
// Shared constants and types for the variable pulse width link block.
// Assumes a 100 MHz clock; all symbol timing is counted in microsecond ticks.
package vpwa_pkg;

  // ----------------------------------------------------------------
  // Clock and tick timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;
  localparam int CYC_PER_US = CLK_HZ / HZ_PER_MHZ;
  localparam int TICK_W = 7;

  // ----------------------------------------------------------------
  // Symbol timing in microseconds
  // ----------------------------------------------------------------
  localparam int US_W = 9;
  localparam logic [8:0] US_MAX = 9'h1FF;
  localparam logic [8:0] RX_A_US = 9'h022;
  localparam logic [8:0] RX_B_US = 9'h060;
  localparam logic [8:0] RX_C_US = 9'h0A3;
  localparam logic [8:0] RX_D_US = 9'h0EF;
  localparam logic [8:0] EOF_US = 9'h118;
  localparam logic [8:0] IFS_US = 9'h12C;
  localparam logic [8:0] ACT_ONE_US = 9'h040;
  localparam logic [8:0] ACT_ZERO_US = 9'h080;
  localparam logic [8:0] PAS_ONE_US = 9'h080;
  localparam logic [8:0] PAS_ZERO_US = 9'h040;
  localparam logic [8:0] SOF_US = 9'h0C8;
  localparam logic [8:0] SETTLE_US = 9'h008;

  // ----------------------------------------------------------------
  // Buffer sizes
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int MSG_MAX = 12;
  localparam logic [3:0] MSG_MAX_CNT = 4'hC;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SYM_INVALID = 3'h0,
    SYM_ONE = 3'h1,
    SYM_ZERO = 3'h2,
    SYM_SOF = 3'h3,
    SYM_BREAK = 3'h4
  } vpwa_sym_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_WAIT = 3'h1,
    TX_SOF = 3'h3,
    TX_BIT = 3'h2,
    TX_EOFW = 3'h6,
    TX_LOSTW = 3'h7,
    TX_TAIL_SYNC = 3'h5,
    TX_TAIL = 3'h4
  } vpwa_state_t;

endpackage : vpwa_pkg

//--- hw/vpwa_tick.sv
// Microsecond tick divider.
// Assumes the shared package clock rate; emits a one-cycle enable pulse.
`timescale 1ns/1ps
module vpwa_tick (
  input wire logic mclk,
  input wire logic rst_b,
  output logic tick
);
  import vpwa_pkg::*;

  localparam logic [TICK_W-1:0] LAST = TICK_W'(CYC_PER_US - 1);

  logic [TICK_W-1:0] cnt_reg;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  assign tick = (cnt_reg == LAST);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
    end else if (tick) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule : vpwa_tick

//--- hw/vpwa_fifo.sv
// Transmit byte FIFO with valid and ready on both sides.
// Assumes one clock; input ready is registered.
`timescale 1ns/1ps
module vpwa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] cnt_reg;
  logic [PW:0] cnt_next;
  logic in_ready_reg;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  wire push = in_valid && in_ready_reg;
  wire pop = out_valid && out_ready;

  assign in_ready = in_ready_reg;
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign cnt_next = cnt_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
      in_ready_reg <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
      cnt_reg <= cnt_next;
      in_ready_reg <= (cnt_next != FULL_CNT);
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

endmodule : vpwa_fifo

//--- test/vpwa_node.sv
// Behavioural model of another node on the shared bus.
// Assumes the design's txp and a wired-OR bus where active dominates.
`timescale 1ns/1ps
module vpwa_node (
  input wire logic mclk,
  input wire logic txp,
  output logic rxp
);
  import vpwa_pkg::*;

  // ------------------------------------------------------------
  // Bus level
  // ------------------------------------------------------------
  logic drv = 1'b0;

  // Active level wins on the shared line
  assign rxp = txp | drv;

  // ------------------------------------------------------------
  // Drive tasks
  // ------------------------------------------------------------
  // Holds one level for a whole number of microseconds
  task automatic phase(input logic lvl, input int us);
    drv = lvl;
    repeat (us * CYC_PER_US) @(posedge mclk);
    #1;
  endtask : phase

  // Sends SOF and one byte, starting with the design's own start
  task automatic frame(input logic [7:0] b);
    logic act;
    int us;
    @(posedge txp);
    @(posedge mclk);
    #1;
    phase(1'b1, 200);
    for (int i = 7; i >= 0; i--) begin
      act = ~i[0];
      us = (b[i] ^ act) ? 128 : 64;
      phase(act, us);
    end
    drv = 1'b0;
  endtask : frame
endmodule : vpwa_node

//--- test/vpw_active_symbol_arbitration_tb.sv
// Self-checking bench: symbol classes, break gap, arbitration, abort.
// Assumes the design package and the node model in vpwa_node.sv.
`timescale 1ns/1ps
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module vpw_active_symbol_arbitration_tb;
  import vpwa_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic rxp, txp, in_ready, rx_sym_valid, bus_idle;
  logic tx_busy, tx_done, tx_lost;
  logic [7:0] in_data = 8'h00;
  logic in_valid = 1'b0;
  logic tx_go = 1'b0;
  logic abort = 1'b0;
  vpwa_sym_t rx_sym, last_sym;
  int bad_count = 0;
  int checks_done = 0;
  int seed = 32'h0000_1b1e;
  int sym_cnt = 0;
  int lost_cnt = 0;
  int rise_cnt = 0;
  int cyc = 0;
  int n;
  int lo[4] = '{5, 40, 100, 168};
  int span[4] = '{25, 50, 58, 65};

  always #5 mclk = ~mclk;

  vpwa_top dut (
    .mclk(mclk),
    .rst_b(rst_b),
    .rxp(rxp),
    .txp(txp),
    .in_data(in_data),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .tx_go(tx_go),
    .transmit_abort_bit(abort),
    .rx_sym(rx_sym),
    .rx_sym_valid(rx_sym_valid),
    .bus_idle(bus_idle),
    .tx_busy(tx_busy),
    .tx_done(tx_done),
    .tx_lost(tx_lost)
  );

  vpwa_node node (
    .mclk(mclk),
    .txp(txp),
    .rxp(rxp)
  );

  // ------------------------------------------------------------
  // Monitors and timeout
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    cyc++;
    if (rx_sym_valid === 1'b1) begin
      last_sym = rx_sym;
      sym_cnt++;
    end
    if (tx_lost === 1'b1) begin
      lost_cnt++;
    end
    if (cyc == 800000) begin
      bad_count++;
      give_verdict();
    end
  end

  always @(posedge txp) rise_cnt++;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic vpwa_sym_t expect_sym(input int len);
    if (len < int'(RX_A_US)) begin
      return SYM_INVALID;
    end
    if (len < int'(RX_B_US)) begin
      return SYM_ONE;
    end
    if (len < int'(RX_C_US)) begin
      return SYM_ZERO;
    end
    if (len < int'(RX_D_US)) begin
      return SYM_SOF;
    end
    return SYM_BREAK;
  endfunction : expect_sym

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick

  // Counts cycles while txp holds one level
  task automatic measure(input logic lvl, output int k);
    k = 0;
    while (txp === lvl && k < 50000) begin
      @(posedge mclk);
      #1;
      k++;
    end
  endtask : measure

  task automatic give_verdict();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int len;
    int n0;
    tick(10);
    rst_b = 1'b1;
    tick(2);
    for (int k = 0; k < 4; k++) begin
      len = lo[k] + ($unsigned($random(seed)) % span[k]);
      n0 = sym_cnt;
      node.phase(1'b1, len);
      node.phase(1'b0, 40);
      `CHK(sym_cnt, n0 + 1)
      `CHK(last_sym, expect_sym(len))
    end
    in_data = 8'h81;
    in_valid = 1'b1;
    tick(1);
    in_valid = 1'b0;
    tick(3);
    tx_go = 1'b1;
    tick(1);
    tx_go = 1'b0;
    tick(2);
    `CHK(tx_busy, 1'b1)
    fork
      node.frame(8'h00);
      begin
        node.phase(1'b1, 250);
        `CHK(last_sym, SYM_BREAK)
        node.phase(1'b0, 290);
        `CHK(txp, 1'b0)
        `CHK(bus_idle, 1'b0)
        tick(1500);
        `CHK(txp, 1'b1)
      end
    join
    `CHK(lost_cnt, 1)
    `CHK(rise_cnt, 1)
    node.frame(8'h80);
    measure(1'b0, n);
    `CHK(n inside {[12700:13000]}, 1'b1)
    measure(1'b1, n);
    `CHK(n inside {[6300:6600]}, 1'b1)
    measure(1'b0, n);
    `CHK(n inside {[27900:28300]}, 1'b1)
    `CHK(lost_cnt, 2)
    tick(5000);
    abort = 1'b1;
    tick(1);
    abort = 1'b0;
    tick(2);
    `CHK(txp, 1'b0)
    `CHK(tx_busy, 1'b0)
    n0 = rise_cnt;
    tick(40000);
    `CHK(rise_cnt, n0)
    `CHK(bus_idle, 1'b1)
    `CHK(in_ready, 1'b1)
    in_data = 8'h5a;
    in_valid = 1'b1;
    tick(1);
    in_valid = 1'b0;
    tick(3);
    tx_go = 1'b1;
    tick(1);
    tx_go = 1'b0;
    n = 0;
    while (tx_done !== 1'b1 && n < 130000) begin
      tick(1);
      n++;
    end
    `CHK(tx_done, 1'b1)
    `CHK(n inside {[123700:125000]}, 1'b1)
    give_verdict();
  end
endmodule : vpw_active_symbol_arbitration_tb
